/* rtl/fspc_flash_ctrl.sv */
// flash self-program controller: bus registers, unlock, operation sequencer
`timescale 1ns/1ps
module fspc_flash_ctrl
    import fspc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data and response
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // flash array
    output logic flash_start,
    output logic [2:0] flash_mode,
    output logic [fspc_pkg::ADDR_W-1:0] flash_addr,
    input wire logic flash_done,
    input wire logic [fspc_pkg::WORD_W-1:0] flash_rdata,
    input wire logic [fspc_pkg::BUF_IDX_W-1:0] flash_buf_index,
    output logic [fspc_pkg::WORD_W-1:0] flash_buf_word,
    // system
    output logic cpu_stall,
    output logic chip_reset_pulse
);
    function automatic logic fspc_reg_hit(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= OFS_STATUS;
    endfunction : fspc_reg_hit

    function automatic logic [3:0] fspc_key_slot(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_KEY_FIRST;
        // msb flags a hit on one of the six key registers
        return (a >= OFS_KEY_FIRST && a <= OFS_KEY_LAST) ? {1'b1, d[4:2]} : 4'h0;
    endfunction : fspc_key_slot

    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] wd;
    logic w_strb0;
    logic wr_fire;
    logic wr_en;
    logic [3:0] wr_key;
    logic [3:0] rd_key;
    logic [7:0] rd_byte;

    fspc_state_e state;
    logic read_trigger_bit;
    logic read_permit_bit;
    logic program_trigger_bit;
    logic [2:0] operation_mode_field;
    logic erase_write_enabled_status;
    logic buffer_clear_bit;
    logic [7:0] chip_reset_key;
    logic [7:0] first_data_low;
    logic [7:0] first_data_high;
    logic [7:0] key_reg [KEY_SLOTS];
    logic unlock_active;
    logic unlock_ok;
    logic main_we;
    logic start_read;
    logic start_prog;
    logic load_word;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_en = wr_fire && w_strb0 && fspc_reg_hit(aw_addr);
    assign wr_key = fspc_key_slot(aw_addr);
    assign rd_key = fspc_key_slot(s_axi_araddr);
    assign main_we = wr_en && aw_addr == OFS_MAIN;
    assign load_word = wr_en && aw_addr == OFS_DATA0_HI;
    // program beats read when both are raised together
    assign start_prog = main_we && wd[BIT_PROG_TRIG] && erase_write_enabled_status && state == ST_IDLE
        && (wd[6:4] == MODE_WRITE || wd[6:4] == MODE_ERASE) && !buffer_clear_bit;
    assign start_read = main_we && wd[BIT_READ_TRIG] && read_permit_bit && wd[6:4] == MODE_READ
        && state == ST_IDLE && !start_prog;

    // write channel: address and data taken in either order, applied once both are held
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= RST_BYTE;
            wd <= RST_BYTE;
            w_strb0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
                wd <= s_axi_wdata[7:0];
                w_strb0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= fspc_reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_byte = RST_BYTE;
        case (s_axi_araddr)
            OFS_MAIN: rd_byte = {erase_write_enabled_status, operation_mode_field, unlock_active,
                program_trigger_bit, read_permit_bit, read_trigger_bit};
            OFS_RESET_KEY: rd_byte = chip_reset_key;
            OFS_BUF_CLR: rd_byte = {7'h00, buffer_clear_bit};
            OFS_ADDR_LO: rd_byte = flash_addr[7:0];
            OFS_ADDR_HI: rd_byte = {3'h0, flash_addr[12:8]};
            OFS_DATA0_LO: rd_byte = first_data_low;
            OFS_DATA0_HI: rd_byte = first_data_high;
            OFS_STATUS: rd_byte = {7'h00, cpu_stall};
            default: rd_byte = rd_key[3] ? key_reg[rd_key[2:0]] : RST_BYTE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= fspc_reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // main control bits
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            operation_mode_field <= RST_MODE;
            read_permit_bit <= 1'b0;
        end else if (main_we) begin
            operation_mode_field <= wd[6:4];
            read_permit_bit <= wd[BIT_READ_PERMIT];
        end
    end

    // set by a good key wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            erase_write_enabled_status <= 1'b0;
        end else if (unlock_ok) begin
            erase_write_enabled_status <= 1'b1;
        end else if (main_we && !wd[BIT_EW_ENABLED]) begin
            erase_write_enabled_status <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            read_trigger_bit <= 1'b0;
            program_trigger_bit <= 1'b0;
        end else begin
            if (start_read) begin
                read_trigger_bit <= 1'b1;
            end else if (state == ST_READ && flash_done) begin
                read_trigger_bit <= 1'b0;
            end
            if (start_prog) begin
                program_trigger_bit <= 1'b1;
            end else if (state == ST_PROG && flash_done) begin
                program_trigger_bit <= 1'b0;
            end
        end
    end

    // operation sequencer; the cpu is held for the whole operation
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            flash_start <= 1'b0;
            flash_mode <= RST_MODE;
            cpu_stall <= 1'b0;
        end else begin
            flash_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_prog) begin
                        state <= ST_PROG;
                        flash_start <= 1'b1;
                        flash_mode <= wd[6:4];
                        cpu_stall <= 1'b1;
                    end else if (start_read) begin
                        state <= ST_READ;
                        flash_start <= 1'b1;
                        flash_mode <= MODE_READ;
                        cpu_stall <= 1'b1;
                    end
                end
                ST_READ, ST_PROG: begin
                    if (flash_done) begin
                        state <= ST_IDLE;
                        cpu_stall <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    cpu_stall <= 1'b0;
                end
            endcase
        end
    end

    // address pair and first data pair
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flash_addr <= RST_ADDR;
            first_data_low <= RST_BYTE;
            first_data_high <= RST_BYTE;
        end else begin
            if (wr_en && aw_addr == OFS_ADDR_LO) begin
                flash_addr[7:0] <= wd;
            end
            if (wr_en && aw_addr == OFS_ADDR_HI) begin
                flash_addr[12:8] <= wd[4:0];
            end
            if (wr_en && aw_addr == OFS_DATA0_LO) begin
                first_data_low <= wd;
            end
            if (load_word) begin
                first_data_high <= wd;
                // stops at the last word so the page never spills over
                if (flash_addr[BUF_IDX_W-1:0] != 5'h1F) begin
                    flash_addr <= flash_addr + 13'h0001;
                end
            end
            if (state == ST_READ && flash_done) begin
                {first_data_high, first_data_low} <= flash_rdata;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            chip_reset_key <= RST_BYTE;
            chip_reset_pulse <= 1'b0;
            buffer_clear_bit <= 1'b0;
        end else begin
            chip_reset_pulse <= wr_en && aw_addr == OFS_RESET_KEY && wd == CHIP_RESET_PATTERN;
            if (wr_en && aw_addr == OFS_RESET_KEY) begin
                chip_reset_key <= wd;
            end
            // clearing every word takes one cycle, then the bit drops
            buffer_clear_bit <= wr_en && aw_addr == OFS_BUF_CLR && wd[BIT_BUF_CLR];
        end
    end

    for (genvar k = 0; k < KEY_SLOTS; k++) begin : g_key
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                key_reg[k] <= RST_BYTE;
            end else if (wr_en && wr_key == {1'b1, 3'(k)}) begin
                key_reg[k] <= wd;
            end
        end
    end

    fspc_unlock_window #(
        .WINDOW_CYCLES(UNLOCK_CYCLES)
    ) u_unlock (
        .clock(clock),
        .arst_n(arst_n),
        .start(main_we && wd[BIT_UNLOCK_TRIG] && wd[6:4] == MODE_EW_ENABLE),
        .key_we(wr_en && wr_key[3]),
        .key_slot(wr_key[2:0]),
        .key_data(wd),
        .active(unlock_active),
        .unlock_ok(unlock_ok)
    );

    fspc_page_buffer u_buffer (
        .clock(clock),
        .arst_n(arst_n),
        .clear(buffer_clear_bit),
        .we(load_word),
        .widx(flash_addr[BUF_IDX_W-1:0]),
        .wdata({wd, first_data_low}),
        .ridx(flash_buf_index),
        .rdata(flash_buf_word)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    read_permit_a: assert property (flash_start && flash_mode == MODE_READ |-> $past(read_permit_bit))
        else $error("read started without read permit");
    read_done_a: assert property (state == ST_READ && flash_done |=> !read_trigger_bit && !cpu_stall)
        else $error("read trigger not cleared after read");
    stall_hold_a: assert property (flash_start |-> cpu_stall && state != ST_IDLE)
        else $error("cpu not stalled during operation");
    chip_reset_a: assert property (main_we |=> !chip_reset_pulse)
        else $error("chip reset from wrong register");
    reset_key_a: assert property (wr_en && aw_addr == OFS_RESET_KEY && wd == CHIP_RESET_PATTERN
        |=> chip_reset_pulse ##1 !chip_reset_pulse)
        else $error("reset pattern gave no single pulse");
    clear_done_a: assert property (buffer_clear_bit |=> !buffer_clear_bit || $past(wr_en))
        else $error("buffer clear bit stuck");
    ew_set_a: assert property (unlock_ok |=> erase_write_enabled_status)
        else $error("good key did not enable erase/write");
    ew_clear_a: assert property (main_we && !wd[BIT_EW_ENABLED] && !unlock_ok |=> !erase_write_enabled_status)
        else $error("enabled status not cleared");
    ew_write1_a: assert property (!erase_write_enabled_status && !unlock_ok |=> !erase_write_enabled_status)
        else $error("enabled status set without unlock");
    prog_gate_a: assert property ($rose(program_trigger_bit) |-> $past(erase_write_enabled_status))
        else $error("program started while locked");
    addr_step_a: assert property (load_word && flash_addr[4:0] != 5'h1F && !(state == ST_READ && flash_done)
        |=> flash_addr == $past(flash_addr) + 13'h0001)
        else $error("address not incremented after word load");

    read_run_c: cover property (start_read ##[1:20] (state == ST_READ && flash_done));
    unlock_run_c: cover property (unlock_ok ##[1:50] start_prog);
    clear_run_c: cover property (load_word ##[1:20] buffer_clear_bit);
endmodule : fspc_flash_ctrl

/* rtl/fspc_pkg.sv */
// constants and types shared by the flash self-program controller
package fspc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int UNLOCK_WINDOW_NS = 20480;
    localparam int UNLOCK_CYCLES = (UNLOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;

    localparam int WORD_W = 16;
    localparam int BUF_WORDS = 32;
    localparam int BUF_IDX_W = 5;
    localparam int ADDR_W = 13;
    localparam int KEY_SLOTS = 6;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_RESET_KEY = 8'h04;
    localparam logic [7:0] OFS_BUF_CLR = 8'h08;
    localparam logic [7:0] OFS_ADDR_LO = 8'h0C;
    localparam logic [7:0] OFS_ADDR_HI = 8'h10;
    localparam logic [7:0] OFS_DATA0_LO = 8'h14;
    localparam logic [7:0] OFS_DATA0_HI = 8'h18;
    localparam logic [7:0] OFS_KEY_FIRST = 8'h1C;
    localparam logic [7:0] OFS_KEY_LAST = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;

    // main control register and buffer clear register bit positions
    localparam int BIT_READ_TRIG = 0;
    localparam int BIT_READ_PERMIT = 1;
    localparam int BIT_PROG_TRIG = 2;
    localparam int BIT_UNLOCK_TRIG = 3;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_EW_ENABLED = 7;
    localparam int BIT_BUF_CLR = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [ADDR_W-1:0] RST_ADDR = 13'h0000;

    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_EW_ENABLE = 3'h6;

    localparam logic [7:0] CHIP_RESET_PATTERN = 8'h55;
    // slot order: pair1 low, pair1 high, pair2 low, pair2 high, pair3 low, pair3 high
    localparam logic [47:0] KEY_PATTERN = 48'h40C3_090D_0400;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_PROG = 2'b10
    } fspc_state_e;
endpackage : fspc_pkg

/* rtl/fspc_page_buffer.sv */
// one-page write buffer of flip-flops with registered read port
`timescale 1ns/1ps
module fspc_page_buffer
    import fspc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // fill side
    input wire logic clear,
    input wire logic we,
    input wire logic [fspc_pkg::BUF_IDX_W-1:0] widx,
    input wire logic [fspc_pkg::WORD_W-1:0] wdata,
    // drain side
    input wire logic [fspc_pkg::BUF_IDX_W-1:0] ridx,
    output logic [fspc_pkg::WORD_W-1:0] rdata
);
    logic [WORD_W-1:0] mem [BUF_WORDS];

    for (genvar g = 0; g < BUF_WORDS; g++) begin : g_word
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                mem[g] <= '0;
            end else if (clear) begin
                mem[g] <= '0;
            end else if (we && widx == BUF_IDX_W'(g)) begin
                mem[g] <= wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[ridx];
        end
    end
endmodule : fspc_page_buffer

/* rtl/fspc_unlock_window.sv */
// key-protected unlock procedure with its window timer
`timescale 1ns/1ps
module fspc_unlock_window
    import fspc_pkg::*;
#(
    parameter int WINDOW_CYCLES = fspc_pkg::UNLOCK_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // software side
    input wire logic start,
    input wire logic key_we,
    input wire logic [2:0] key_slot,
    input wire logic [7:0] key_data,
    // status
    output logic active,
    output logic unlock_ok
);
    logic [TIMER_W-1:0] count;
    logic [KEY_SLOTS-1:0] match;
    logic [KEY_SLOTS-1:0] next_match;

    always_comb begin
        next_match = match;
        if (key_we && key_slot < 3'(KEY_SLOTS)) begin
            next_match[key_slot] = (key_data == KEY_PATTERN[8*key_slot +: 8]);
        end
    end

    // window timer; a fresh start re-arms it and forgets old key bytes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active <= 1'b0;
            count <= '0;
        end else if (start) begin
            active <= 1'b1;
            count <= TIMER_W'(WINDOW_CYCLES - 1);
        end else if (active) begin
            if (count == '0) begin
                active <= 1'b0;
            end else begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            match <= '0;
        end else if (start || !active || count == '0) begin
            match <= '0;
        end else begin
            match <= next_match;
        end
    end

    // only a pattern completed inside the window counts
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            unlock_ok <= 1'b0;
        end else begin
            unlock_ok <= active && !start && count != '0 && key_we && (&next_match);
        end
    end
endmodule : fspc_unlock_window

/* bench/fspc_flash_model.sv */
// flash array stand-in: answers each start with done after a short or long delay
`timescale 1ns/1ps
module fspc_flash_model (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // from controller; slow and pick come from the bench
    input wire logic flash_start,
    input wire logic [fspc_pkg::ADDR_W-1:0] flash_addr,
    input wire logic slow,
    input wire logic [fspc_pkg::BUF_IDX_W-1:0] pick,
    // to controller
    output logic flash_done,
    output logic [fspc_pkg::WORD_W-1:0] flash_rdata,
    output logic [fspc_pkg::BUF_IDX_W-1:0] flash_buf_index
);
    logic [5:0] left;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            left <= 6'h00;
        end else if (flash_start) begin
            left <= slow ? 6'h28 : 6'h03;
        end else if (left != 6'h00) begin
            left <= left - 6'h01;
        end
    end
    // done never lands beside start
    assign flash_done = (left == 6'h01);
    // word valid only with done; churns otherwise so stale data is not mistaken
    assign flash_rdata = flash_done ? ({3'h0, flash_addr} ^ 16'hA5C3) : ({10'h000, left} ^ 16'h5A5A);
    // idle array lets the bench pick which buffer word to look at
    assign flash_buf_index = (left == 6'h00) ? pick : left[4:0];
endmodule : fspc_flash_model

/* bench/tb_flash_self_program_control.sv */
// register-level bench of the flash self-program controller
`timescale 1ns/1ps
module tb_flash_self_program_control;
    import fspc_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fstart, fdone, stall, rst_pulse;
    logic [1:0] bresp, rresp, resp;
    logic [12:0] faddr;
    logic [15:0] frdata;
    logic [4:0] fidx;
    logic [4:0] pick = 5'h1F;
    logic [2:0] fmode;
    logic [15:0] bword;
    int err_total = 0, samples_checked = 0, n_start = 0, n_rst = 0;
    logic [7:0] key [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};

    fspc_flash_ctrl dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_start(fstart),
        .flash_mode(fmode), .flash_addr(faddr), .flash_done(fdone), .flash_rdata(frdata),
        .flash_buf_index(fidx), .flash_buf_word(bword), .cpu_stall(stall), .chip_reset_pulse(rst_pulse));
    fspc_flash_model model (.clock(clock), .arst_n(arst_n), .flash_start(fstart), .flash_addr(faddr),
        .slow(slow), .pick(pick), .flash_done(fdone), .flash_rdata(frdata), .flash_buf_index(fidx));

    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        n_start <= n_start + int'(fstart);
        n_rst <= n_rst + int'(rst_pulse);
    end

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_go, w_go, aw_done = 1'b0, w_done = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            aw_go = !aw_done && awready;
            w_go = !w_done && wready;
            tick();
            aw_done = aw_done | aw_go;
            w_done = w_done | w_go;
            awvalid <= !aw_done;
            wvalid <= !w_done;
        end
        while (!bvalid) tick();
        resp = bresp;
        // bready stays up so back-to-back calls never retoggle it in one step
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic go = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!go) begin
            go = arready;
            tick();
        end
        arvalid <= 1'b0;
        while (!rvalid) tick();
        v = rdata;
        resp = rresp;
        tick();
    endtask : rd
    task automatic unlock(input logic [7:0] last);
        wr(OFS_MAIN, 8'h60);
        wr(OFS_MAIN, 8'h68);
        for (int j = 0; j < 6; j++) wr(OFS_KEY_FIRST + 8'(4 * j), (j == 5) ? last : key[j]);
    endtask : unlock
    task automatic idle();
        while (stall) tick();
    endtask : idle
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        tick();
        rd(OFS_RESET_KEY);
        chk(v, 32'h0);
        rd(8'h3C);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        // only the pattern value fires the chip reset
        wr(OFS_RESET_KEY, 8'h54);
        wr(OFS_RESET_KEY, CHIP_RESET_PATTERN);
        tick();
        tick();
        chk(n_rst, 1);
        rd(OFS_RESET_KEY);
        chk(v, 32'h55);
        wr(OFS_BUF_CLR, 8'hFF);
        tick();
        rd(OFS_BUF_CLR);
        chk(v, 32'h0);
        // read refused without permit, then run with permit set earlier
        wr(OFS_ADDR_LO, 8'h21);
        wr(OFS_ADDR_HI, 8'h03);
        wr(OFS_MAIN, 8'h30);
        wr(OFS_MAIN, 8'h31);
        chk(n_start, 0);
        wr(OFS_MAIN, 8'h32);
        slow <= 1'b1;
        wr(OFS_MAIN, 8'h33);
        chk(stall, 1'b1);
        chk(fmode, MODE_READ);
        idle();
        rd(OFS_MAIN);
        chk(v, 32'h32);
        rd(OFS_DATA0_LO);
        chk(v, 32'hE2);
        rd(OFS_DATA0_HI);
        chk(v, 32'hA6);
        // address steps once then holds at the page end
        wr(OFS_ADDR_LO, 8'h1E);
        wr(OFS_DATA0_HI, 8'h12);
        wr(OFS_DATA0_HI, 8'h13);
        rd(OFS_ADDR_LO);
        chk(v, 32'h1F);
        chk(bword, 16'h13E2);
        pick <= 5'h1E;
        tick();
        tick();
        chk(bword, 16'h12E2);
        wr(OFS_MAIN, 8'h94);
        chk(n_start, 1);
        rd(OFS_MAIN);
        chk(v & 32'h84, 32'h0);
        unlock(8'h41);
        repeat (2100) tick();
        wr(OFS_KEY_FIRST + 8'h14, 8'h40);
        tick();
        tick();
        rd(OFS_MAIN);
        chk(v & 32'h88, 32'h0);
        unlock(8'h40);
        tick();
        tick();
        rd(OFS_MAIN);
        chk(v & 32'h80, 32'h80);
        slow <= 1'b0;
        wr(OFS_MAIN, 8'h94);
        idle();
        chk(fmode, MODE_ERASE);
        // read back the erased page before programming it
        wr(OFS_MAIN, 8'hB2);
        wr(OFS_MAIN, 8'hB3);
        idle();
        rd(OFS_DATA0_LO);
        chk(v, 32'hDC);
        wr(OFS_MAIN, 8'h84);
        idle();
        chk(fmode, MODE_WRITE);
        chk(n_start, 4);
        rd(OFS_MAIN);
        chk(v & 32'h84, 32'h80);
        wr(OFS_BUF_CLR, 8'h01);
        tick();
        chk(bword, 16'h0000);
        wr(OFS_MAIN, 8'h00);
        wr(OFS_MAIN, 8'h04);
        chk(n_start, 4);
        complete_run();
    end
endmodule : tb_flash_self_program_control
